// ---- chip_reset_sequencer.sv ----
// top of the chip reset sequencer
`timescale 1ns/100ps
`include "crs_defines.svh"
module crs_chip_reset_sequencer
    import crs_pkg::*;
#(
    parameter int PIN_DELAY_CYC = `CRS_PIN_DELAY_CYC,
    parameter int SRC_DELAY_CYC = `CRS_SRC_DELAY_CYC
) (
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  rstn,
    // reset sources
    input  wire logic  reset_pin_n,
    input  wire logic  watchdog_timer_reset,
    input  wire logic  core_sw_reset_request,
    // cause flags
    input  wire logic  reset_cause_clear,
    output logic [2:0] reset_cause_flags,
    // chip reset and clock select
    output logic       internal_reset_n,
    output logic       ext_clock_select
);
    // -----------------------------
    // local state
    // -----------------------------
    crs_sync_if  sync ();
    crs_state_e  state_q, state_d;
    logic [21:0] cnt_q, cnt_d;
    logic        rst_n_q, rst_n_d;
    crs_flags_t  flags_q, flags_d;
    logic [1:0]  wdt_dly_q, wdt_dly_d;
    logic [1:0]  raw_dly_q, raw_dly_d;
    logic        rst_out_q, rst_out_d;
    logic        clk_sel_q, clk_sel_d;
    logic        src_seen;
    logic        src_is_wdt;
    logic        raw_active;

    // -----------------------------
    // counter limits
    // -----------------------------
    // counter is 22 bits wide, so delays beyond about four million cycles do not fit
    localparam logic [21:0] PIN_LAST = 22'(PIN_DELAY_CYC - 1);
    localparam logic [21:0] SRC_LAST = 22'(SRC_DELAY_CYC - 1);

    // -----------------------------
    // helpers
    // -----------------------------
    // any raw source asking for reset; the pin is active low
    function automatic logic src_active(input logic pin_n, input logic wdt, input logic sw);
        return ~pin_n | wdt | sw;
    endfunction : src_active

    // one-hot cause word; pin over watchdog over core request
    function automatic crs_flags_t cause_flags(input logic from_pin, input logic from_wdt);
        crs_flags_t f;
        f = 3'h0;
        if (from_pin) begin
            f[`CRS_FLAG_PIN] = 1'b1;
        end else if (from_wdt) begin
            f[`CRS_FLAG_WDT] = 1'b1;
        end else begin
            f[`CRS_FLAG_SW] = 1'b1;
        end
        return f;
    endfunction : cause_flags

    // -----------------------------
    // source synchroniser
    // -----------------------------
    crs_sync u_sync (
        .sys_clk               (sys_clk),
        .rstn                  (rstn),
        .reset_pin_n           (reset_pin_n),
        .watchdog_timer_reset  (watchdog_timer_reset),
        .core_sw_reset_request (core_sw_reset_request),
        .sync                  (sync)
    );

    assign src_seen   = sync.src_req;
    assign src_is_wdt = wdt_dly_q[1];
    assign raw_active = src_active(reset_pin_n, watchdog_timer_reset, core_sw_reset_request);

    // -----------------------------
    // source delay lines
    // -----------------------------
    // watchdog bit rides beside the merged request, so the cause is read in the
    // same cycle as the request, even for a one-cycle pulse
    always_comb begin
        wdt_dly_d = {wdt_dly_q[0], watchdog_timer_reset};
        raw_dly_d = {raw_dly_q[0], raw_active};
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdt_dly_q <= 2'h0;
            raw_dly_q <= 2'h3;
        end else begin
            wdt_dly_q <= wdt_dly_d;
            raw_dly_q <= raw_dly_d;
        end
    end

    // -----------------------------
    // sequencing
    // -----------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        rst_n_d = rst_n_q;
        unique case (state_q)
            CRS_HOLD_PIN: begin
                rst_n_d = 1'b0;
                if (sync.pin_low) begin
                    cnt_d = 22'h0;
                end else if (cnt_q >= PIN_LAST) begin
                    state_d = CRS_RUN;
                    rst_n_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 22'h1;
                end
            end
            CRS_HOLD_SRC: begin
                rst_n_d = 1'b0;
                if (sync.pin_low) begin
                    // a pin press inside a source hold still earns the full pin delay
                    state_d = CRS_HOLD_PIN;
                    cnt_d   = 22'h0;
                end else if (cnt_q >= SRC_LAST) begin
                    state_d = CRS_RUN;
                    rst_n_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 22'h1;
                end
            end
            CRS_RUN: begin
                cnt_d = 22'h0;
                if (sync.pin_low) begin
                    state_d = CRS_HOLD_PIN;
                    rst_n_d = 1'b0;
                end else if (src_seen) begin
                    state_d = CRS_HOLD_SRC;
                    rst_n_d = 1'b0;
                end
            end
        endcase
    end

    // -----------------------------
    // sequencing registers
    // -----------------------------
    // power-on reset counts as a pin reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= CRS_HOLD_PIN;
            cnt_q   <= 22'h0;
            rst_n_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            rst_n_q <= rst_n_d;
        end
    end

    // -----------------------------
    // reset cause flags
    // -----------------------------
    // a new cause beats a clear in the same cycle; clears are refused in hold
    always_comb begin
        flags_d = flags_q;
        if (reset_cause_clear && rst_n_q) begin
            flags_d = 3'h0;
        end
        if (state_q == CRS_RUN) begin
            if (sync.pin_low) begin
                flags_d = cause_flags(1'b1, 1'b0);
            end else if (src_seen) begin
                flags_d = cause_flags(1'b0, src_is_wdt);
            end
        end
    end

    // flags survive warm resets so software can read the cause
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= `CRS_FLAG_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // -----------------------------
    // outputs
    // -----------------------------
    // raw sources and their delayed copies hold reset low until the
    // synchronised state catches up, so a short pulse gives no glitch
    always_comb begin
        rst_out_d = rst_n_d & ~raw_active & ~raw_dly_q[0] & ~raw_dly_q[1];
        clk_sel_d = `CRS_CLKSEL_RST;
    end

    // clock select sits on the internal oscillator out of every reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_out_q <= 1'b0;
            clk_sel_q <= `CRS_CLKSEL_RST;
        end else begin
            rst_out_q <= rst_out_d;
            clk_sel_q <= clk_sel_d;
        end
    end

    assign internal_reset_n  = rst_out_q;
    assign reset_cause_flags = flags_q;
    assign ext_clock_select  = clk_sel_q;
endmodule : crs_chip_reset_sequencer

// ---- crs_defines.svh ----
// constants for the chip reset sequencer
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
`define CRS_CLK_HZ        40000000
`define CRS_PIN_DELAY_US  1600
`define CRS_PIN_DELAY_CYC ((`CRS_CLK_HZ / 1000000) * `CRS_PIN_DELAY_US)
`define CRS_SRC_DELAY_CYC 30
`define CRS_PIN_MIN_CYC   12
`define CRS_FLAG_PIN      0
`define CRS_FLAG_WDT      1
`define CRS_FLAG_SW       2
`define CRS_FLAG_RST      3'h1
`define CRS_CLKSEL_RST    1'h0
`endif

// ---- crs_pkg.sv ----
// types of the chip reset sequencer
package crs_pkg;
    typedef enum logic [1:0] {
        CRS_HOLD_PIN,
        CRS_HOLD_SRC,
        CRS_RUN
    } crs_state_e;
    typedef logic [2:0] crs_flags_t;
endpackage : crs_pkg

// ---- crs_sync_if.sv ----
// interface carrying the synchronised reset sources
`timescale 1ns/100ps
interface crs_sync_if;
    logic pin_low;
    logic src_req;
    modport prod (output pin_low, output src_req);
    modport cons (input pin_low, input src_req);
endinterface : crs_sync_if

// ---- crs_sync.sv ----
// two-stage synchroniser of the reset sources
`timescale 1ns/100ps
module crs_sync
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // raw sources
    input  wire logic reset_pin_n,
    input  wire logic watchdog_timer_reset,
    input  wire logic core_sw_reset_request,
    // synchronised out
    crs_sync_if.prod  sync
);
    logic [1:0] pin_q, pin_d;
    logic [1:0] src_q, src_d;

    // -----------------------------
    // sync stages
    // -----------------------------
    always_comb begin
        pin_d = {pin_q[0], ~reset_pin_n};
        src_d = {src_q[0], watchdog_timer_reset | core_sw_reset_request};
    end

    // pin stages preset high: chip counts as held until the pin is seen high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 2'h3;
            src_q <= 2'h0;
        end else begin
            pin_q <= pin_d;
            src_q <= src_d;
        end
    end

    assign sync.pin_low = pin_q[1];
    assign sync.src_req = src_q[1];
endmodule : crs_sync

// ---- crs_props.sv ----
// checker of the chip reset sequencer
`timescale 1ns/100ps
module crs_props #(
    parameter int PIN_DELAY_CYC = 64000,
    parameter int SRC_DELAY_CYC = 30
) (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       reset_pin_n,
    input wire logic       watchdog_timer_reset,
    input wire logic       core_sw_reset_request,
    input wire logic       reset_cause_clear,
    input wire logic [2:0] reset_cause_flags,
    input wire logic       internal_reset_n,
    input wire logic       ext_clock_select
);
    // counters, since the holds run far past any repetition
    int pin_q;
    int low_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 0;
            low_q <= 0;
        end else begin
            pin_q <= reset_pin_n ? pin_q + 1 : 0;
            low_q <= internal_reset_n ? 0 : low_q + 1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_pin_asserts: assert property (!reset_pin_n |=> !internal_reset_n)
        else $error("pin low did not reset");
    chk_src_asserts: assert property ((watchdog_timer_reset || core_sw_reset_request) |=> !internal_reset_n)
        else $error("source did not reset");
    chk_osc_select: assert property (!ext_clock_select)
        else $error("external clock selected");
    // pin high for less time than reset was low: the release follows a pin press
    chk_pin_delay: assert property ($rose(internal_reset_n) && pin_q < low_q |->
        pin_q >= PIN_DELAY_CYC && pin_q <= PIN_DELAY_CYC + 5) else $error("pin release delay wrong");
    chk_src_delay: assert property ($rose(internal_reset_n) && pin_q >= low_q |->
        low_q >= SRC_DELAY_CYC && low_q <= SRC_DELAY_CYC + 8) else $error("source release delay wrong");
    chk_flag_onehot: assert property (internal_reset_n |-> $onehot0(reset_cause_flags))
        else $error("cause not one-hot");
    chk_cause_clear: assert property (reset_cause_clear && internal_reset_n |=> reset_cause_flags == 3'h0)
        else $error("clear ignored");
    chk_flag_stable: assert property (low_q > 4 |-> $stable(reset_cause_flags))
        else $error("cause changed in hold");
endmodule : crs_props

// ---- crs_partner.sv ----
// model of the board reset circuit, watchdog and core
`timescale 1ns/100ps
module crs_partner (
    input wire logic sys_clk,
    output logic     reset_pin_n,
    output logic     watchdog_timer_reset,
    output logic     core_sw_reset_request
);
    initial begin
        reset_pin_n = 1'b0;
        watchdog_timer_reset = 1'b0;
        core_sw_reset_request = 1'b0; // core keeps nothing across a reset
    end
    // never shorter than twelve cycles
    task automatic pin_low(input int n);
        @(negedge sys_clk) reset_pin_n <= 1'b0;
        repeat (n < 12 ? 12 : n) @(negedge sys_clk);
        reset_pin_n <= 1'b1;
    endtask : pin_low
    // watchdog or core request, held for three cycles
    task automatic pulse(input logic wdt);
        @(negedge sys_clk);
        if (wdt) watchdog_timer_reset <= 1'b1;
        else core_sw_reset_request <= 1'b1;
        repeat (3) @(negedge sys_clk);
        watchdog_timer_reset <= 1'b0;
        core_sw_reset_request <= 1'b0;
    endtask : pulse
endmodule : crs_partner

// ---- tb_chip_reset_sequencer.sv ----
// self-checking bench of the chip reset sequencer
`timescale 1ns/100ps
module tb_chip_reset_sequencer;
    logic       sys_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       clr = 1'b0;
    logic       pin_n, wdt, sw, int_n, csel;
    logic [2:0] flags;
    logic [2:0] exp_q[$];
    int         num_errors = 0;
    int         checked = 0;
    int         cyc = 0;
    int         k, kind;
    crs_chip_reset_sequencer #(.PIN_DELAY_CYC(50), .SRC_DELAY_CYC(30)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
        .reset_pin_n(pin_n), .watchdog_timer_reset(wdt), .core_sw_reset_request(sw), .reset_cause_clear(clr),
        .reset_cause_flags(flags), .internal_reset_n(int_n), .ext_clock_select(csel));
    crs_partner i_part (.sys_clk(sys_clk), .reset_pin_n(pin_n), .watchdog_timer_reset(wdt),
        .core_sw_reset_request(sw));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // bounded, so a stuck reset shows as a mismatch
    task automatic wait_run;
        int n;
        n = 0;
        while (int_n !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        check({2'h0, int_n}, 3'h1);
    endtask : wait_run
    always @(posedge int_n) begin
        #1;
        if (exp_q.size() > 0) check(flags, exp_q.pop_front());
        else check(flags, 3'hx);
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h7bfb));
        for (k = 0; k < 24; k++) begin
            kind = $urandom_range(2, 0);
            if (k % 12 == 0) begin
                exp_q.push_back(3'h1); // power-up, then power restored mid-run
                fork
                    i_part.pin_low(40);
                    begin
                        @(negedge sys_clk) rstn <= 1'b0;
                        repeat (12) @(negedge sys_clk);
                        rstn <= 1'b1;
                    end
                join
            end else begin
                exp_q.push_back(3'h1 << kind);
                if (kind == 0) i_part.pin_low(12 + $urandom_range(7, 0));
                else i_part.pulse(kind == 1);
                if (k % 6 == 5) i_part.pin_low(12); // pin pressed inside a hold
            end
            // clear while held must be refused
            @(negedge sys_clk) clr <= 1'b1;
            @(negedge sys_clk) clr <= 1'b0;
            wait_run();
            if (k % 2 == 1) begin
                @(negedge sys_clk) clr <= 1'b1;
                @(negedge sys_clk) clr <= 1'b0;
                @(negedge sys_clk) check(flags, 3'h0);
            end
            check({2'h0, csel}, 3'h0);
        end
        summarize();
    end
endmodule : tb_chip_reset_sequencer
bind crs_chip_reset_sequencer crs_props #(.PIN_DELAY_CYC(PIN_DELAY_CYC), .SRC_DELAY_CYC(SRC_DELAY_CYC)) i_props (
    .sys_clk(sys_clk), .rstn(rstn), .reset_pin_n(reset_pin_n), .watchdog_timer_reset(watchdog_timer_reset),
    .core_sw_reset_request(core_sw_reset_request), .reset_cause_clear(reset_cause_clear),
    .reset_cause_flags(reset_cause_flags), .internal_reset_n(internal_reset_n), .ext_clock_select(ext_clock_select));
